// >>> src/ana_pkg.sv
// Shared constants for the auto-negotiation ability register bank
package ana_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 5;
  localparam int          DATA_W          = 16;
  localparam logic [4:0]  LOCAL_ADV_OFS   = 5'h04;
  localparam logic [4:0]  PEER_CAP_OFS    = 5'h05;
  localparam logic [4:0]  ADV_STATUS_OFS  = 5'h10;

  // ----------------------------------------------------------------
  // Field positions, shared by both ability words
  // ----------------------------------------------------------------
  localparam int MORE_PAGES_BIT  = 15;
  localparam int ACK_BIT         = 14;
  localparam int FAULT_BIT       = 13;
  localparam int SPARE_BIT       = 12;
  localparam int ASYM_FLOW_BIT   = 11;
  localparam int FLOW_BIT        = 10;
  localparam int FOURPAIR_BIT    = 9;
  localparam int FAST_FULL_BIT   = 8;
  localparam int FAST_HALF_BIT   = 7;
  localparam int SLOW_FULL_BIT   = 6;
  localparam int SLOW_HALF_BIT   = 5;
  localparam int SPEED_LSB       = 5;
  localparam int SPEED_W         = 4;
  localparam int SELECT_LSB      = 0;
  localparam int SELECT_W        = 5;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [15:0] LOCAL_ADV_RESET = 16'h0001;
  localparam logic [15:0] PEER_CAP_RESET  = 16'h0000;
  localparam logic [15:0] LOCAL_WR_MASK   = 16'hBFFF;
  localparam logic [15:0] LOCAL_TX_MASK   = 16'hADFF;
  localparam logic [15:0] PEER_RD_MASK    = 16'hEFFF;
  localparam logic [3:0]  SPEED_NOSTRAP   = 4'hF;
  localparam logic [4:0]  SELECT_8023     = 5'h01;
  localparam logic [15:0] READ_ZERO       = 16'h0000;

  // ----------------------------------------------------------------
  // Strap capture timing
  // ----------------------------------------------------------------
  localparam int          SYNC_STAGES     = 2;
  localparam logic [1:0]  STRAP_SETTLE    = 2'h2;

  typedef enum logic [2:0] {
    ANA_ST_SETTLE = 3'b001,
    ANA_ST_LOAD   = 3'b010,
    ANA_ST_RUN    = 3'b100
  } ana_state_t;

endpackage

// >>> src/ana_sync2.sv
// Two-flip-flop level synchroniser for pin inputs
module ana_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // First stage feeds only the second stage
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule

// >>> src/ana_ability_regs.sv
// Local advertisement and link partner ability registers
module ana_ability_regs (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        strap_cfg_en,
  input  wire logic [3:0]  strap_speed,
  input  wire logic        peer_word_valid,
  input  wire logic [15:0] peer_word,
  input  wire logic        an_complete,
  input  wire logic        an_restart,
  input  wire logic        np_supported,
  output logic      [15:0] local_adv_word,
  output logic      [15:0] peer_cap_word,
  output logic             adv_stale,
  output logic             strap_loaded
);

  // ----------------------------------------------------------------
  // Strap pins: synchronised, then caught once after reset release
  // ----------------------------------------------------------------
  logic [4:0] strap_raw;
  logic [4:0] strap_sync;

  assign strap_raw = {strap_cfg_en, strap_speed};

  ana_sync2 #(
    .WIDTH (5)
  ) u_strap_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .async_in (strap_raw),
    .sync_out (strap_sync)
  );

  ana_pkg::ana_state_t state_reg;
  ana_pkg::ana_state_t state_next;
  logic [1:0]          settle_reg;
  logic [1:0]          settle_next;

  always_comb begin
    state_next  = state_reg;
    settle_next = settle_reg;
    unique case (state_reg)
      ana_pkg::ANA_ST_SETTLE: begin
        // Wait for the synchroniser to hold post-reset strap levels
        if (settle_reg == ana_pkg::STRAP_SETTLE) begin
          state_next = ana_pkg::ANA_ST_LOAD;
        end else begin
          settle_next = settle_reg + 2'h1;
        end
      end
      ana_pkg::ANA_ST_LOAD: begin
        state_next = ana_pkg::ANA_ST_RUN;
      end
      ana_pkg::ANA_ST_RUN: begin
        state_next = ana_pkg::ANA_ST_RUN;
      end
      default: begin
        state_next = ana_pkg::ANA_ST_SETTLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg  <= ana_pkg::ANA_ST_SETTLE;
      settle_reg <= 2'h0;
    end else begin
      state_reg  <= state_next;
      settle_reg <= settle_next;
    end
  end

  logic [3:0] strap_default;

  always_comb begin
    if (strap_sync[4]) begin
      strap_default = strap_sync[3:0];
    end else begin
      strap_default = ana_pkg::SPEED_NOSTRAP;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic hit_local;
  logic hit_peer;
  logic hit_status;
  logic wr_local;

  always_comb begin
    hit_local  = (reg_addr == ana_pkg::LOCAL_ADV_OFS);
    hit_peer   = (reg_addr == ana_pkg::PEER_CAP_OFS);
    hit_status = (reg_addr == ana_pkg::ADV_STATUS_OFS);
    wr_local   = reg_wr && hit_local;
  end

  // ----------------------------------------------------------------
  // Local advertisement register
  // ----------------------------------------------------------------
  logic [15:0] local_reg;
  logic [15:0] local_next;

  always_comb begin
    local_next = local_reg;
    if (state_reg == ana_pkg::ANA_ST_LOAD) begin
      local_next[ana_pkg::SPEED_LSB +: ana_pkg::SPEED_W] = strap_default;
    end
    // A software write in the load cycle overrides the strap value
    if (wr_local) begin
      local_next = reg_wdata & ana_pkg::LOCAL_WR_MASK;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      local_reg <= ana_pkg::LOCAL_ADV_RESET;
    end else begin
      local_reg <= local_next;
    end
  end

  // Unsupported four-pair and spare bit never reach the link
  assign local_adv_word = local_reg & ana_pkg::LOCAL_TX_MASK;

  // ----------------------------------------------------------------
  // Stale advertisement flag
  // ----------------------------------------------------------------
  logic stale_reg;
  logic stale_next;

  always_comb begin
    stale_next = stale_reg;
    if (an_restart) begin
      stale_next = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (wr_local && !an_complete) begin
      stale_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stale_reg <= 1'b0;
    end else begin
      stale_reg <= stale_next;
    end
  end

  assign adv_stale = stale_reg;

  // ----------------------------------------------------------------
  // Partner ability capture
  // ----------------------------------------------------------------
  logic [15:0] peer_reg;
  logic [15:0] peer_next;
  logic        peer_take;

  always_comb begin
    // Base page only before completion; later pages only when next pages run
    peer_take = peer_word_valid && (!an_complete || np_supported);
    peer_next = peer_reg;
    if (peer_take) begin
      peer_next = peer_word & ana_pkg::PEER_RD_MASK;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      peer_reg <= ana_pkg::PEER_CAP_RESET;
    end else begin
      peer_reg <= peer_next;
    end
  end

  assign peer_cap_word = peer_reg;

  // ----------------------------------------------------------------
  // Read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [15:0] status_word;

  always_comb begin
    status_word    = ana_pkg::READ_ZERO;
    status_word[0] = stale_reg;
    status_word[1] = (state_reg == ana_pkg::ANA_ST_RUN);
    rdata_next     = ana_pkg::READ_ZERO;
    if (reg_rd) begin
      if (hit_local) begin
        rdata_next = local_reg;
      end else if (hit_peer) begin
        rdata_next = peer_reg;
      end else if (hit_status) begin
        rdata_next = status_word;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= ana_pkg::READ_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata    = rdata_reg;
  assign strap_loaded = (state_reg == ana_pkg::ANA_ST_RUN);

endmodule

// >>> verif/ana_ability_regs_sva.sv
// Port-level checker for the ability register bank
module ana_ability_regs_sva (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [4:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        strap_cfg_en,
  input wire logic [3:0]  strap_speed,
  input wire logic        peer_word_valid,
  input wire logic [15:0] peer_word,
  input wire logic        an_complete,
  input wire logic        an_restart,
  input wire logic        np_supported,
  input wire logic [15:0] local_adv_word,
  input wire logic [15:0] peer_cap_word,
  input wire logic        adv_stale,
  input wire logic        strap_loaded
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero");
  AST_RD_LOCAL: assert property (reg_rd && reg_addr == 5'h04 |=>
    (reg_rdata & 16'hEDFF) == $past(local_adv_word))
    else $error("local read wrong");
  AST_RD_PEER: assert property (reg_rd && reg_addr == 5'h05 |=> reg_rdata == $past(peer_cap_word))
    else $error("partner read wrong");
  AST_RSVD: assert property ((local_adv_word & 16'h5200) == 16'h0000 && !peer_cap_word[12])
    else $error("reserved bit set");
  AST_WRITE: assert property (reg_wr && reg_addr == 5'h04 && strap_loaded |=>
    local_adv_word == ($past(reg_wdata) & 16'hADFF))
    else $error("write not applied");
  AST_STRAP: assert property ($rose(strap_loaded) |->
    local_adv_word[8:5] == (strap_cfg_en ? strap_speed : 4'hF))
    else $error("strap default wrong");
  AST_CAPTURE: assert property (peer_word_valid && (!an_complete || np_supported) |=>
    peer_cap_word == ($past(peer_word) & 16'hEFFF))
    else $error("capture wrong");
  AST_REFUSE: assert property (peer_word_valid && an_complete && !np_supported |=> $stable(peer_cap_word))
    else $error("late word taken");
  AST_HOLD: assert property (!peer_word_valid |=> $stable(peer_cap_word))
    else $error("partner word changed");
  AST_STALE_SET: assert property (reg_wr && reg_addr == 5'h04 && !an_complete |=> adv_stale)
    else $error("stale not set");
  AST_STALE_CLR: assert property (an_restart && !(reg_wr && reg_addr == 5'h04 && !an_complete) |=>
    !adv_stale)
    else $error("stale not cleared");
  cover property (reg_rd && reg_addr == 5'h05);
  cover property (peer_word_valid && an_complete && np_supported);
  cover property ($rose(adv_stale));
  cover property (an_restart && reg_wr && reg_addr == 5'h04 && !an_complete);
endmodule

bind ana_ability_regs ana_ability_regs_sva u_ana_ability_regs_sva (.*);

// >>> verif/ana_peer_model.sv
// Link partner model handing over received code words
module ana_peer_model (
  input  wire logic        clk,
  output logic             peer_word_valid,
  output logic      [15:0] peer_word
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    peer_word_valid = 1'b0;
    peer_word       = 16'h0000;
  end
  task automatic send(input logic [15:0] w);
    @(posedge clk);
    peer_word_valid <= 1'b1;
    peer_word       <= w;
    @(posedge clk);
    peer_word_valid <= 1'b0;
    // Inverted when idle so a late sample cannot match
    peer_word       <= ~w;
    // Let the captured word settle before the caller looks
    #1;
  endtask
endmodule

// >>> verif/ana_ability_regs_bench.sv
// Self-checking bench for the ability register bank
module ana_ability_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, arst_n, reg_wr, reg_rd, strap_cfg_en, peer_word_valid;
  logic        an_complete, an_restart, np_supported, adv_stale, strap_loaded;
  logic [4:0]  reg_addr;
  logic [3:0]  strap_speed;
  logic [15:0] reg_wdata, reg_rdata, peer_word, local_adv_word, peer_cap_word;
  int          fail_count;
  int          checks_done;

  ana_ability_regs u_ana_ability_regs (.*);
  ana_peer_model u_ana_peer_model (.clk(clk), .peer_word_valid(peer_word_valid), .peer_word(peer_word));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic restart();
    @(posedge clk);
    an_restart <= 1'b1;
    @(posedge clk);
    an_restart <= 1'b0;
    #1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset(input logic cfg, input logic [3:0] spd, input logic [15:0] exp);
    @(posedge clk);
    arst_n       <= 1'b0;
    strap_cfg_en <= cfg;
    strap_speed  <= spd;
    repeat (5) @(posedge clk);
    #1;
    chk(local_adv_word, 16'h0001);
    chk(peer_cap_word, 16'h0000);
    chk({15'h0000, strap_loaded}, 16'h0000);
    @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk({15'h0000, strap_loaded}, 16'h0001);
    rd(5'h04, exp);
    rd(5'h05, 16'h0000);
    rd(5'h10, 16'h0002);
    rd(5'h1F, 16'h0000);
  endtask

  task automatic t_local();
    wr(5'h04, 16'hFFFF);
    chk(local_adv_word, 16'hADFF);
    rd(5'h04, 16'hBFFF);
    wr(5'h04, 16'h1201);
    chk(local_adv_word, 16'h0001);
    rd(5'h04, 16'h1201);
    wr(5'h04, 16'h401E);
    rd(5'h04, 16'h001E);
    wr(5'h05, 16'hFFFF);
    rd(5'h05, 16'h0000);
  endtask

  task automatic t_stale();
    an_complete <= 1'b0;
    restart();
    chk({15'h0000, adv_stale}, 16'h0000);
    wr(5'h04, 16'h0001);
    chk({15'h0000, adv_stale}, 16'h0001);
    restart();
    an_complete <= 1'b1;
    wr(5'h04, 16'h0001);
    chk({15'h0000, adv_stale}, 16'h0000);
    // Write and restart in one cycle: the set must win
    an_complete <= 1'b0;
    @(posedge clk);
    reg_wr     <= 1'b1;
    reg_addr   <= 5'h04;
    reg_wdata  <= 16'h0001;
    an_restart <= 1'b1;
    @(posedge clk);
    reg_wr     <= 1'b0;
    an_restart <= 1'b0;
    #1;
    chk({15'h0000, adv_stale}, 16'h0001);
    rd(5'h10, 16'h0003);
  endtask

  task automatic t_capture();
    an_complete  <= 1'b0;
    np_supported <= 1'b0;
    u_ana_peer_model.send(16'hFFFF);
    chk(peer_cap_word, 16'hEFFF);
    rd(5'h05, 16'hEFFF);
    an_complete <= 1'b1;
    u_ana_peer_model.send(16'h1234);
    chk(peer_cap_word, 16'hEFFF);
    np_supported <= 1'b1;
    u_ana_peer_model.send(16'h5A5A);
    chk(peer_cap_word, 16'h4A5A);
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    // Watchdog: every wait is fixed, so this only trips on a hang
    #100000;
    fail_count++;
    give_verdict();
  end

  initial begin
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    strap_cfg_en = 1'b0;
    strap_speed = 4'h0;
    an_complete = 1'b0;
    an_restart = 1'b0;
    np_supported = 1'b0;
    fail_count = 0;
    checks_done = 0;
    t_reset(1'b0, 4'h5, 16'h01E1);
    t_local();
    t_stale();
    t_capture();
    t_reset(1'b1, 4'hA, 16'h0141);
    give_verdict();
  end
endmodule
